// ### rtl/fwubh_defs.svh
`ifndef FWUBH_DEFS_SVH
`define FWUBH_DEFS_SVH

// Register byte addresses
`define FWUBH_A_CTRL 8'h00
`define FWUBH_A_HDR 8'h04
`define FWUBH_A_IMG 8'h08
`define FWUBH_A_CMD 8'h0c
`define FWUBH_A_STAT 8'h10
`define FWUBH_A_REV 8'h14
`define FWUBH_A_XFER 8'h18
`define FWUBH_A_CRC 8'h1c
`define FWUBH_A_COMPAT 8'h20

// Control and command fields
`define FWUBH_CTRL_ENTER 0
`define FWUBH_CTRL_EXIT 1
`define FWUBH_CMD_PEC_OK 8
`define FWUBH_CMD_HAS_DATA 9
`define FWUBH_CMD_CLEAR 8'he0

// Header layout, zero based byte index
`define FWUBH_HDR_LEN 6'd32
`define FWUBH_H_CRC 0
`define FWUBH_H_OFS 2
`define FWUBH_H_SIZE 4
`define FWUBH_H_SECT 6
`define FWUBH_H_KEY 8
`define FWUBH_H_NAME 10
`define FWUBH_H_RSVD 22
`define FWUBH_H_MAJ 23
`define FWUBH_H_MINP 24
`define FWUBH_H_MINS 25
`define FWUBH_H_HW1 26
`define FWUBH_H_HW2 27
`define FWUBH_H_BLK 28
`define FWUBH_H_WT 30

// Image check and program store
`define FWUBH_CRC_INIT 16'hffff
`define FWUBH_CRC_POLY 16'h1021
`define FWUBH_BOOT_END 16'h1000
`define FWUBH_HW_REV1 8'h01
`define FWUBH_HW_REV2 8'h00

// Write time unit
`define FWUBH_CLK_NS 10
`define FWUBH_WT_UNIT_NS 1000
`define FWUBH_WT_UNIT_CYC (`FWUBH_WT_UNIT_NS / `FWUBH_CLK_NS)

`endif

// ### rtl/fwubh_pkg.sv
package fwubh_pkg;

	typedef enum logic [1:0] {
		FWUBH_BOOT = 2'b00,
		FWUBH_MAIN = 2'b01,
		FWUBH_UPLOAD = 2'b10,
		FWUBH_CHECK = 2'b11
	} fwubh_mode_e;

	typedef struct packed {
		logic [15:0] crc;
		logic [15:0] offset;
		logic [15:0] size;
		logic [15:0] sector;
		logic [15:0] key;
		logic down_rev;
		logic [6:0] major;
		logic [7:0] minor_first;
		logic [7:0] minor_second;
		logic [7:0] hw_first;
		logic [7:0] hw_second;
		logic [15:0] block_size;
		logic [15:0] write_time;
	} fwubh_hdr_s;

	typedef struct packed {
		logic boot_viol;
		logic overrun;
		logic crc_err;
		logic compat_err;
	} fwubh_flags_s;

endpackage : fwubh_pkg

// ### rtl/fwubh_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwubh_defs.svh"

module fwubh_crc16 (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Byte stream
	input wire logic init,
	input wire logic en,
	input wire logic [7:0] data,
	// Running value
	output logic [15:0] crc
);
	logic [15:0] crc_reg;
	logic [15:0] crc_next;

	always_comb begin
		logic [15:0] c;
		c = crc_reg ^ {data, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ `FWUBH_CRC_POLY) : (c << 1);
		end
		if (init) begin
			crc_next = `FWUBH_CRC_INIT;
		end else if (en) begin
			crc_next = c;
		end else begin
			crc_next = crc_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			crc_reg <= `FWUBH_CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

	assign crc = crc_reg;
endmodule : fwubh_crc16
`default_nettype wire

// ### rtl/fwubh_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwubh_defs.svh"

module fwubh_core #(
	parameter logic [15:0] BOOT_END = `FWUBH_BOOT_END,
	parameter logic [7:0] HW_REV1 = `FWUBH_HW_REV1,
	parameter logic [7:0] HW_REV2 = `FWUBH_HW_REV2,
	parameter logic [6:0] WT_UNIT_CYC = 7'(`FWUBH_WT_UNIT_CYC)
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Power state
	input wire logic ac_present,
	input wire logic power_on_request_n,
	input wire logic nv_main_valid,
	// Program store
	output logic prog_we,
	output logic [15:0] prog_addr,
	output logic [7:0] prog_data,
	// Supply control
	output logic run_main,
	output logic upload_active,
	output logic output_enable,
	output logic fan_enable,
	output logic protect_enable,
	output logic clear_event_records,
	output logic image_valid,
	output logic record_access_en
);
	fwubh_pkg::fwubh_mode_e mode_reg, mode_next;
	fwubh_pkg::fwubh_flags_s flags_reg, flags_next;
	fwubh_pkg::fwubh_hdr_s hdr;
	logic [7:0] hdr_mem [0:31];
	logic [5:0] hdr_cnt_reg, hdr_cnt_next;
	logic [15:0] img_cnt_reg, img_cnt_next;
	logic [15:0] blk_cnt_reg, blk_cnt_next;
	logic [22:0] wait_reg, wait_next;
	logic boot_done_reg, boot_done_next;
	logic valid_reg, valid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic we_reg, we_next;
	logic [15:0] paddr_reg, paddr_next;
	logic [7:0] pdata_reg, pdata_next;
	logic clr_reg, clr_next;
	logic out_en_reg;
	logic crc_init, crc_en;
	logic [15:0] crc_val;
	logic hdr_wr, img_wr, busy, hdr_done, img_done, upload_ok, check_ok;
	logic [15:0] img_addr;

	function automatic logic [15:0] hdr_word(input int idx, input logic [7:0] m [0:31]);
		hdr_word = {m[idx + 1], m[idx]};
	endfunction : hdr_word

	function automatic logic wr_at(input logic [7:0] a, input logic [7:0] target, input logic wr);
		wr_at = wr && (a == target);
	endfunction : wr_at

	// Header field view; model name and spare byte are kept but not decoded
	always_comb begin
		hdr.crc = hdr_word(`FWUBH_H_CRC, hdr_mem);
		hdr.offset = hdr_word(`FWUBH_H_OFS, hdr_mem);
		hdr.size = hdr_word(`FWUBH_H_SIZE, hdr_mem);
		hdr.sector = hdr_word(`FWUBH_H_SECT, hdr_mem);
		hdr.key = hdr_word(`FWUBH_H_KEY, hdr_mem);
		hdr.down_rev = hdr_mem[`FWUBH_H_MAJ][7];
		hdr.major = hdr_mem[`FWUBH_H_MAJ][6:0];
		hdr.minor_first = hdr_mem[`FWUBH_H_MINP];
		hdr.minor_second = hdr_mem[`FWUBH_H_MINS];
		hdr.hw_first = hdr_mem[`FWUBH_H_HW1];
		hdr.hw_second = hdr_mem[`FWUBH_H_HW2];
		hdr.block_size = hdr_word(`FWUBH_H_BLK, hdr_mem);
		hdr.write_time = hdr_word(`FWUBH_H_WT, hdr_mem);
	end

	assign busy = (wait_reg != 23'h000000);
	assign hdr_done = (hdr_cnt_reg == `FWUBH_HDR_LEN);
	assign img_done = hdr_done && (img_cnt_reg == hdr.size);
	assign hdr_wr = wr_at(reg_addr, `FWUBH_A_HDR, reg_wr) && (mode_reg == fwubh_pkg::FWUBH_UPLOAD);
	assign img_wr = wr_at(reg_addr, `FWUBH_A_IMG, reg_wr) && (mode_reg == fwubh_pkg::FWUBH_UPLOAD);
	assign img_addr = hdr.offset + img_cnt_reg;
	// Boot loader accepts upload in any power state, main program only when on
	assign upload_ok = (mode_reg == fwubh_pkg::FWUBH_BOOT) ||
		((mode_reg == fwubh_pkg::FWUBH_MAIN) && ac_present && !power_on_request_n);
	assign check_ok = img_done && (crc_val == hdr.crc) && !flags_reg.boot_viol &&
		(hdr.hw_first == HW_REV1) && (hdr.hw_second == HW_REV2);

	fwubh_crc16 u_crc (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.init(crc_init),
		.en(crc_en),
		.data(reg_wdata[7:0]),
		.crc(crc_val)
	);

	// Header store; byte 22 is stored but never read by the checks
	always_ff @(posedge clk_sys) begin
		if (hdr_wr && !hdr_done) begin
			hdr_mem[hdr_cnt_reg[4:0]] <= reg_wdata[7:0];
		end
	end

	// Mode sequencing and transfer
	always_comb begin
		mode_next = mode_reg;
		flags_next = flags_reg;
		hdr_cnt_next = hdr_cnt_reg;
		img_cnt_next = img_cnt_reg;
		blk_cnt_next = blk_cnt_reg;
		wait_next = busy ? wait_reg - 23'h000001 : wait_reg;
		boot_done_next = 1'b1;
		valid_next = valid_reg;
		we_next = 1'b0;
		paddr_next = paddr_reg;
		pdata_next = pdata_reg;
		crc_init = 1'b0;
		crc_en = 1'b0;
		case (mode_reg)
			fwubh_pkg::FWUBH_BOOT: begin
				// Always start here after reset; main runs only from a known good image
				if (!boot_done_reg && nv_main_valid) begin
					mode_next = fwubh_pkg::FWUBH_MAIN;
				end
				if (wr_at(reg_addr, `FWUBH_A_CTRL, reg_wr) && reg_wdata[`FWUBH_CTRL_ENTER] && upload_ok) begin
					mode_next = fwubh_pkg::FWUBH_UPLOAD;
				end
			end
			fwubh_pkg::FWUBH_MAIN: begin
				if (wr_at(reg_addr, `FWUBH_A_CTRL, reg_wr) && reg_wdata[`FWUBH_CTRL_ENTER] && upload_ok) begin
					mode_next = fwubh_pkg::FWUBH_UPLOAD;
				end
			end
			fwubh_pkg::FWUBH_UPLOAD: begin
				if (hdr_wr) begin
					if (!hdr_done) begin
						hdr_cnt_next = hdr_cnt_reg + 6'd1;
					end else begin
						flags_next.overrun = 1'b1;
					end
				end
				if (img_wr) begin
					if (!hdr_done || img_done || busy) begin
						flags_next.overrun = 1'b1;
					end else begin
						crc_en = 1'b1;
						img_cnt_next = img_cnt_reg + 16'h0001;
						if (img_addr < BOOT_END) begin
							flags_next.boot_viol = 1'b1;
						end else begin
							we_next = 1'b1;
							paddr_next = img_addr;
							pdata_next = reg_wdata[7:0];
						end
						// Host must pace blocks; bytes sent during the write wait are dropped, not stalled
						if (blk_cnt_reg + 16'h0001 >= hdr.block_size) begin
							blk_cnt_next = 16'h0000;
							wait_next = 23'(hdr.write_time) * 23'(WT_UNIT_CYC);
						end else begin
							blk_cnt_next = blk_cnt_reg + 16'h0001;
						end
					end
				end
				if (wr_at(reg_addr, `FWUBH_A_CTRL, reg_wr) && reg_wdata[`FWUBH_CTRL_EXIT] && !busy) begin
					mode_next = fwubh_pkg::FWUBH_CHECK;
				end
			end
			fwubh_pkg::FWUBH_CHECK: begin
				// Swap to the new image on exit, no power cycle
				valid_next = check_ok;
				if (check_ok) begin
					mode_next = fwubh_pkg::FWUBH_MAIN;
				end else begin
					mode_next = fwubh_pkg::FWUBH_BOOT;
					flags_next.crc_err = !img_done || (crc_val != hdr.crc);
					flags_next.compat_err = (hdr.hw_first != HW_REV1) ||
						(hdr.hw_second != HW_REV2);
				end
			end
			default: begin
				mode_next = fwubh_pkg::FWUBH_BOOT;
			end
		endcase
		// Fresh upload: image no longer trusted, old store is being overwritten
		if (mode_reg != fwubh_pkg::FWUBH_UPLOAD && mode_next == fwubh_pkg::FWUBH_UPLOAD) begin
			flags_next = '0;
			hdr_cnt_next = 6'd0;
			img_cnt_next = 16'h0000;
			blk_cnt_next = 16'h0000;
			wait_next = 23'h000000;
			valid_next = 1'b0;
			crc_init = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= fwubh_pkg::FWUBH_BOOT;
			flags_reg <= '0;
			hdr_cnt_reg <= 6'd0;
			img_cnt_reg <= 16'h0000;
			blk_cnt_reg <= 16'h0000;
			wait_reg <= 23'h000000;
			boot_done_reg <= 1'b0;
			valid_reg <= 1'b0;
			we_reg <= 1'b0;
			paddr_reg <= 16'h0000;
			pdata_reg <= 8'h00;
		end else begin
			mode_reg <= mode_next;
			flags_reg <= flags_next;
			hdr_cnt_reg <= hdr_cnt_next;
			img_cnt_reg <= img_cnt_next;
			blk_cnt_reg <= blk_cnt_next;
			wait_reg <= wait_next;
			boot_done_reg <= boot_done_next;
			valid_reg <= valid_next;
			we_reg <= we_next;
			paddr_reg <= paddr_next;
			pdata_reg <= pdata_next;
		end
	end

	// Register reads and event record clear, served in every power state
	always_comb begin
		clr_next = wr_at(reg_addr, `FWUBH_A_CMD, reg_wr) &&
			(reg_wdata[7:0] == `FWUBH_CMD_CLEAR) && reg_wdata[`FWUBH_CMD_PEC_OK] &&
			!reg_wdata[`FWUBH_CMD_HAS_DATA];
		rdata_next = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				`FWUBH_A_STAT: begin
					rdata_next = {20'h00000, mode_reg, busy, flags_reg, valid_reg,
						hdr_done, img_done, run_main, upload_active};
				end
				`FWUBH_A_REV: begin
					rdata_next = {8'h00, hdr.down_rev, hdr.major, hdr.minor_first,
						hdr.minor_second};
				end
				`FWUBH_A_XFER: begin
					rdata_next = {hdr.write_time, hdr.block_size};
				end
				`FWUBH_A_CRC: begin
					rdata_next = {hdr.crc, crc_val};
				end
				`FWUBH_A_COMPAT: begin
					rdata_next = {16'h0000, hdr.hw_first, hdr.hw_second};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= 32'h00000000;
			clr_reg <= 1'b0;
			out_en_reg <= 1'b0;
			run_main <= 1'b0;
			upload_active <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			clr_reg <= clr_next;
			out_en_reg <= !power_on_request_n;
			run_main <= (mode_next == fwubh_pkg::FWUBH_MAIN);
			upload_active <= (mode_next == fwubh_pkg::FWUBH_UPLOAD);
		end
	end

	// Basic supply functions stay on in every mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fan_enable <= 1'b0;
			protect_enable <= 1'b0;
			record_access_en <= 1'b0;
		end else begin
			fan_enable <= 1'b1;
			protect_enable <= 1'b1;
			record_access_en <= 1'b1;
		end
	end

	assign reg_rdata = rdata_reg;
	assign prog_we = we_reg;
	assign prog_addr = paddr_reg;
	assign prog_data = pdata_reg;
	assign clear_event_records = clr_reg;
	assign output_enable = out_en_reg;
	assign image_valid = valid_reg;
endmodule : fwubh_core
`default_nettype wire

// ### dv/fwubh_core_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwubh_defs.svh"

module fwubh_core_props #(
	parameter logic [15:0] BOOT_END = `FWUBH_BOOT_END
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	// Power state and store
	input wire logic ac_present,
	input wire logic power_on_request_n,
	input wire logic nv_main_valid,
	input wire logic prog_we,
	input wire logic [15:0] prog_addr,
	// Supply control
	input wire logic run_main,
	input wire logic upload_active,
	input wire logic output_enable,
	input wire logic fan_enable,
	input wire logic protect_enable,
	input wire logic clear_event_records,
	input wire logic record_access_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic enter_wr;
	logic clr_wr;
	assign enter_wr = reg_wr && reg_addr == `FWUBH_A_CTRL && reg_wdata[0];
	// Valid checksum, no data byte
	assign clr_wr = reg_wr && reg_addr == `FWUBH_A_CMD && reg_wdata[9:0] == 10'h1e0;

	AST_SUPPLY_ON: assert property ($past(nrst) |-> fan_enable && protect_enable
		&& record_access_en) else $error("supply function off after reset");
	AST_OUT_FOLLOW: assert property ($past(nrst)
		|-> output_enable == !$past(power_on_request_n)) else $error("output not following request");
	AST_BOOT_START: assert property ($past(nrst) && !$past(nrst, 2)
		|=> run_main == $past(nv_main_valid, 2) && !upload_active) else $error("bad start mode");
	// A second command right behind the first legally stretches the pulse
	AST_CLEAR_PULSE: assert property (clr_wr ##1 !clr_wr
		|-> clear_event_records ##1 !clear_event_records) else $error("clear pulse wrong");
	AST_CLEAR_CAUSE: assert property (clear_event_records |-> $past(clr_wr))
		else $error("clear without command");
	AST_BOOT_GUARD: assert property (prog_we |-> prog_addr >= BOOT_END)
		else $error("boot region written");
	// Check state shows neither bit but ignores entry, so leave it out
	AST_ENTER_BOOT: assert property (enter_wr && !run_main && !upload_active
		&& !$past(upload_active) |=> upload_active) else $error("upload refused in boot");
	AST_ENTER_MAIN: assert property (enter_wr && run_main
		|=> upload_active == (ac_present && !power_on_request_n)) else $error("main enter wrong");
	AST_NO_EARLY_RUN: assert property (upload_active |-> !run_main)
		else $error("main runs during upload");

	cover property (clr_wr ##1 clear_event_records);
	cover property ($rose(run_main));
	cover property (enter_wr && run_main && power_on_request_n);
endmodule : fwubh_core_props

bind fwubh_core fwubh_core_props #(.BOOT_END(BOOT_END)) u_props (.*);

`default_nettype wire

// ### dv/fwubh_store_model.sv
`timescale 1ns/1ps
`default_nettype none

module fwubh_store_model (
	// Clock
	input wire logic clk_sys,
	// Program store write
	input wire logic prog_we,
	input wire logic [15:0] prog_addr,
	input wire logic [7:0] prog_data
);
	logic [7:0] mem [logic [15:0]];
	int n_wr = 0;

	// Main region only; new bytes replace old with no backup
	always @(posedge clk_sys) begin
		if (prog_we === 1'b1) begin
			mem[prog_addr] = prog_data;
			n_wr++;
		end
	end
endmodule : fwubh_store_model

`default_nettype wire

// ### dv/test_firmware_update_boot_header.sv
`timescale 1ns/1ps
`default_nettype none
`include "fwubh_defs.svh"

module test_firmware_update_boot_header;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ac_present = 1'b1;
	logic power_on_request_n = 1'b0;
	logic nv_main_valid = 1'b0;
	logic [31:0] reg_rdata;
	logic prog_we, run_main, upload_active, output_enable, fan_enable;
	logic protect_enable, clear_event_records, image_valid, record_access_en;
	logic [15:0] prog_addr;
	logic [7:0] prog_data;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [31:0] v;
	logic [7:0] hdr [32];
	// Host keeps the full image for the whole update
	logic [7:0] img [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	logic [31:0] cmds [3] = '{32'h1e0, 32'h0e0, 32'h3e0};

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	fwubh_core #(.WT_UNIT_CYC(7'h01)) dut_u (.*);
	fwubh_store_model store_u (.*);

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// Mode, flags, valid and run bits only
	task automatic stat(input logic [8:0] e);
		rd(`FWUBH_A_STAT);
		chk("stat", {23'h0, v[11:10], v[8:4], v[1:0]}, {23'h0, e});
	endtask : stat

	// Bytes sent during busy are dropped, so wait it out
	task automatic idle();
		for (int k = 0; k < 50; k++) begin
			rd(`FWUBH_A_STAT);
			if (v[9] === 1'b0)
				return;
		end
		chk("busy", 32'h1, 32'h0);
		summarize();
	endtask : idle

	function automatic logic [15:0] crc16(input int n);
		logic [15:0] c;
		c = `FWUBH_CRC_INIT;
		for (int i = 0; i < n; i++) begin
			c = c ^ {img[i], 8'h00};
			for (int b = 0; b < 8; b++)
				c = c[15] ? (c << 1) ^ `FWUBH_CRC_POLY : c << 1;
		end
		return c;
	endfunction : crc16

	task automatic upload(input logic [15:0] ofs, input logic [7:0] hw1);
		logic [15:0] c;
		c = crc16(4);
		hdr = '{default: 8'h4d};
		{hdr[1], hdr[0], hdr[3], hdr[2], hdr[5], hdr[4]} = {c, ofs, 16'h0004};
		// Reserved byte set to junk; must be ignored
		{hdr[22], hdr[23], hdr[24], hdr[25]} = 32'hff85_0709;
		{hdr[26], hdr[27]} = {hw1, `FWUBH_HW_REV2};
		{hdr[29], hdr[28], hdr[31], hdr[30]} = 32'h0002_0001;
		for (int i = 0; i < 32; i++)
			wr(`FWUBH_A_HDR, {24'h0, hdr[i]});
		for (int i = 0; i < 4; i++) begin
			wr(`FWUBH_A_IMG, {24'h0, img[i]});
			idle();
		end
	endtask : upload

	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		stat(9'h000);
		chk("fan", 32'({fan_enable, protect_enable, record_access_en}), 32'h7);
		rd(8'h24);
		chk("unmapped", v, 32'h0);
		rd(`FWUBH_A_CTRL);
		chk("write only", v, 32'h0);
		power_on_request_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk("out", 32'(output_enable), 32'h0);
		power_on_request_n <= 1'b0;
		$display("reset test done");
		foreach (cmds[i]) begin
			wr(`FWUBH_A_CMD, cmds[i]);
			#1 chk("clear", 32'(clear_event_records), 32'(i == 0));
		end
		$display("clear test done");
		wr(`FWUBH_A_CTRL, 32'h1);
		upload(16'h2000, `FWUBH_HW_REV1);
		rd(`FWUBH_A_REV);
		chk("rev", v, 32'h0085_0709);
		@(posedge clk_sys);
		#1 chk("rdata idle", reg_rdata, 32'h0);
		rd(`FWUBH_A_XFER);
		chk("xfer", v, 32'h0001_0002);
		rd(`FWUBH_A_COMPAT);
		chk("compat", v, {16'h0, `FWUBH_HW_REV1, `FWUBH_HW_REV2});
		rd(`FWUBH_A_CRC);
		chk("crc", v, {crc16(4), crc16(4)});
		chk("stored", 32'(store_u.mem[16'h2003]), 32'h44);
		chk("early run", 32'(run_main), 32'h0);
		wr(`FWUBH_A_CTRL, 32'h2);
		stat(9'h086);
		chk("good valid", 32'(image_valid), 32'h1);
		$display("good image test done");
		power_on_request_n <= 1'b1;
		wr(`FWUBH_A_CTRL, 32'h1);
		stat(9'h086);
		power_on_request_n <= 1'b0;
		ac_present <= 1'b0;
		wr(`FWUBH_A_CTRL, 32'h1);
		stat(9'h086);
		// Standby-only supply still serves event records
		wr(`FWUBH_A_CMD, 32'h1e0);
		#1 chk("clear standby", 32'(clear_event_records), 32'h1);
		ac_present <= 1'b1;
		wr(`FWUBH_A_CTRL, 32'h1);
		#1 chk("enter", 32'(upload_active), 32'h1);
		upload(16'h2000, 8'h02);
		wr(`FWUBH_A_HDR, 32'h0);
		wr(`FWUBH_A_CTRL, 32'h2);
		stat(9'h028);
		chk("bad valid", 32'(image_valid), 32'h0);
		$display("main entry test done");
		wr(`FWUBH_A_CTRL, 32'h1);
		upload(16'h0ffe, `FWUBH_HW_REV1);
		wr(`FWUBH_A_CTRL, 32'h2);
		stat(9'h040);
		chk("writes", 32'(store_u.n_wr), 32'd10);
		chk("boot kept", 32'(store_u.mem.exists(16'h0fff)), 32'h0);
		// Exit with no image: rejected, and upload can be entered again
		wr(`FWUBH_A_CTRL, 32'h1);
		wr(`FWUBH_A_CTRL, 32'h2);
		stat(9'h010);
		$display("boot guard test done");
		nv_main_valid <= 1'b1;
		nrst <= 1'b0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		stat(9'h082);
		$display("restart test done");
		summarize();
	end
endmodule : test_firmware_update_boot_header

`default_nettype wire
